// ### dsw_dc_cmp.sv
// dc link voltage comparisons with registered results
module dsw_dc_cmp
  import dsw_pkg::*;
(
  input  wire logic    mclk,        // system clock
  input  wire logic    rstn,        // async reset, active low
  input  wire dsw_dc_t dc,          // measurements and limits
  input  wire logic    interlock,   // internal charge interlock
  output logic         in_tol_r,    // actual within tolerance
  output logic         above_r,     // actual above threshold
  output logic         dc_low_r,    // actual below opening level
  output logic         chg_sw_r     // charging switch closed
);
  logic [DC_W-1:0] diff;

  // magnitude of error, no sign bit needed
  assign diff = (dc.actual >= dc.reference) ?
                DC_W'(dc.actual - dc.reference) :
                DC_W'(dc.reference - dc.actual);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      in_tol_r <= 1'b0;
      above_r  <= 1'b0;
      dc_low_r <= 1'b1;
    end else begin
      in_tol_r <= (diff <= dc.tolerance);
      above_r  <= (dc.actual > dc.threshold);
      dc_low_r <= (dc.actual < dc.open_level);
    end
  end

  // hysteresis between closing limit and opening level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chg_sw_r <= 1'b0;
    end else if (interlock || dc.actual < dc.open_level) begin
      chg_sw_r <= 1'b0;
    end else if (dc.actual > dc.close_limit) begin
      chg_sw_r <= 1'b1;
    end
  end
endmodule // dsw_dc_cmp

// ### dsw_master.sv
// fieldbus master model: periodic control words with watchdog toggle
module dsw_master (
  input  wire logic        mclk,       // system clock
  input  wire logic        rstn,       // async reset, active low
  input  wire logic        toggle_en,  // toggle bit 11 on each word
  input  wire logic [15:0] base,       // remaining control word bits
  output logic      [15:0] cw,         // control word to the drive
  output logic             cw_stb      // one-cycle word strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  import dsw_pkg::*;
  logic        ph_r;
  logic        wd_r;
  logic        wd_nxt;
  logic [15:0] word;

  assign wd_nxt = (ph_r && toggle_en) ? !wd_r : wd_r;
  always_comb begin
    word = base;
    word[CW_BIT_WDOG] = wd_nxt;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ph_r   <= 1'b0;
      wd_r   <= 1'b0;
      cw_stb <= 1'b0;
      cw     <= 16'h0000;
    end else begin
      ph_r   <= !ph_r;
      wd_r   <= wd_nxt;
      cw_stb <= ph_r;
      // word is only valid with the strobe, so scramble it otherwise
      cw     <= ph_r ? word : ~word;
    end
  end
endmodule // dsw_master

// ### dsw_pkg.sv
// shared constants and types for the drive status word builder
package dsw_pkg;

  // control word fields taken from the fieldbus master
  localparam int CW_W          = 16;
  localparam int CW_BIT_ON     = 0;
  localparam int CW_BIT_RESET  = 7;
  localparam int CW_BIT_WDOG   = 11;

  // fieldbus status word bit positions
  localparam int FS_READY_ON   = 0;
  localparam int FS_READY_RUN  = 1;
  localparam int FS_RUNNING    = 2;
  localparam int FS_FAULT      = 3;
  localparam int FS_RUN_EN     = 4;
  localparam int FS_NO_QSTOP   = 5;
  localparam int FS_BRK_AGREE  = 6;
  localparam int FS_WARNING    = 7;
  localparam int FS_IN_TOL     = 8;
  localparam int FS_FB_CTRL    = 9;
  localparam int FS_ABOVE      = 10;
  localparam int FS_CHARGE     = 14;
  localparam int FS_WD_ECHO    = 15;

  // application status word bit positions
  localparam int AS_READY      = 1;
  localparam int AS_RUNNING    = 2;
  localparam int AS_FAULT      = 3;
  localparam int AS_RUN_EN     = 6;
  localparam int AS_WARNING    = 7;
  localparam int AS_CHG_SW     = 8;
  localparam int AS_BRK_CMD    = 9;
  localparam int AS_BRK_FB     = 10;
  localparam int AS_CHG_CTRL   = 11;
  localparam int AS_RUN_REQ    = 12;

  // values after reset
  localparam logic [15:0] FS_RST = 16'h0000;
  localparam logic [15:0] AS_RST = 16'h0000;
  localparam logic [15:0] CW_RST = 16'h0000;

  // watchdog timeout setting counts in milliseconds
  localparam int CLK_PERIOD_NS = 5;
  localparam int WD_UNIT_NS    = 1000000;
  localparam int WD_TICK_CYC   = WD_UNIT_NS / CLK_PERIOD_NS;
  localparam int WD_SET_W      = 16;

  localparam int DC_W          = 16;

  // drive internal state, all on mclk
  typedef struct packed {
    logic fault;           // any fault active
    logic warning;         // any warning active
    logic run_enable_in;   // run enable input level
    logic forced_open;     // breaker forced open command
    logic quick_stop;      // quick stop command active
    logic dc_ready;        // dc link ready
    logic brk_close_cmd;   // final breaker close command
    logic brk_feedback;    // breaker feedback, 1 = closed
    logic brk_request;     // application breaker close request
    logic brk_internal;    // internal breaker close status
    logic run_state;       // in run state
    logic modulating;      // actively modulating
    logic fb_ctrl_active;  // fieldbus holds control
    logic charge_out;      // dc charging output command
    logic charge_cont;     // charging contactor commanded closed
    logic mc_run_enable;   // run enable presented to motor control
    logic mc_run_request;  // final run request to motor control
    logic start_ready;     // ready to accept start
    logic interlock;       // internal charge interlock active
  } dsw_drive_t;

  // dc link measurements and limits
  typedef struct packed {
    logic [DC_W-1:0] actual;
    logic [DC_W-1:0] reference;
    logic [DC_W-1:0] tolerance;
    logic [DC_W-1:0] threshold;
    logic [DC_W-1:0] close_limit;
    logic [DC_W-1:0] open_level;
  } dsw_dc_t;

endpackage

// ### dsw_status.sv
// status word builder: fieldbus and application status words
//
// What this block does
// - enabled watchdog stops toggling, drive enters fault state.
// - watchdog timeout setting zero disables watchdog supervision.
// - bit 0 set only with no fault, run enable, no forced open, no quick stop.
// - bit 1 set with control bit 0, dc ready, close command, feedback.
// - bit 2 set while in run state and modulating.
// - bit 3 set while in fault state.
// - bit 4 set when running enabled, cleared by any coast-stop cause.
// - bit 5 inverted: zero while quick stop active.
// - bit 6 reports agreement of breaker request and internal status.
// - bit 7 follows any warning, clears itself, drive keeps running.
// - bit 8 set when dc voltage within tolerance of reference.
// - bit 9 set while fieldbus holds control.
// - bit 10 set when dc voltage above configurable threshold.
// - bits 11 to 13 reserved, carry zero.
// - bit 14 follows dc charging output command.
// - bit 15 echoes last received control word bit 11.
// - application bit 1 ready for start, zero on low dc or fault.
// - application bits 2, 3, 7 give modulating, fault, warning.
// - application bit 6 mirrors run enable to motor control.
// - application bit 8 charging switch closed with hysteresis.
// - application bits 9 and 10 give breaker command and feedback.
// - application bits 11 and 12 give charge contactor and run request.
module dsw_status
  import dsw_pkg::*;
#(
  parameter int TICK_CYC = dsw_pkg::WD_TICK_CYC  // cycles per millisecond
)(
  input  wire logic                          mclk,        // 200 MHz clock
  input  wire logic                          rstn,        // async reset
  input  wire logic [dsw_pkg::CW_W-1:0]      cw,          // control word
  input  wire logic                          cw_stb,      // cw valid pulse
  input  wire logic [dsw_pkg::WD_SET_W-1:0]  wd_timeout,  // ms, 0 = off
  input  wire dsw_pkg::dsw_drive_t           drive,       // drive state
  input  wire dsw_pkg::dsw_dc_t              dc,          // dc link values
  output logic [15:0]                        fb_status,   // fieldbus word
  output logic [15:0]                        app_status,  // application word
  output logic                               fault_state, // drive faulted
  output logic                               wd_fault,    // watchdog trip
  output logic                               fb_changed,  // fb word moved
  output logic                               app_changed  // app word moved
);
  import dsw_pkg::*;

  // latched control word and derived strobes
  logic [CW_W-1:0] cw_r;
  logic            cw_seen_r;
  logic            wd_toggled;
  logic            fault_ack;

  // dc comparison results
  logic            dc_in_tol;
  logic            dc_above;
  logic            dc_low;
  logic            chg_sw;

  // watchdog expiry
  logic            wd_expired;

  // combined fault
  logic            fault_any;

  // next values of the two words
  logic [15:0]     fs_nxt;
  logic [15:0]     as_nxt;
  logic [15:0]     fs_r;
  logic [15:0]     as_r;
  logic            fb_chg_r;
  logic            app_chg_r;

  // named status terms
  logic            ready_on;
  logic            ready_run;
  logic            running;
  logic            coast_stop;
  logic            run_enabled;
  logic            no_qstop;
  logic            brk_agree;
  logic            app_ready;

  // control word capture, only on the master's strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cw_r <= CW_RST;
    end else if (cw_stb) begin
      cw_r <= cw;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cw_seen_r <= 1'b0;
    end else if (cw_stb) begin
      cw_seen_r <= 1'b1;
    end
  end

  // master toggles bit 11; a change restarts the timeout
  assign wd_toggled = cw_stb && cw_seen_r &&
                      (cw[CW_BIT_WDOG] != cw_r[CW_BIT_WDOG]);

  // positive edge of the acknowledge bit clears the watchdog trip
  assign fault_ack = cw_stb && cw[CW_BIT_RESET] && !cw_r[CW_BIT_RESET];

  dsw_wdog #(
    .TICK_CYC (TICK_CYC)
  ) u_wdog (
    .mclk      (mclk),
    .rstn      (rstn),
    .cw_stb    (cw_stb),
    .toggled   (wd_toggled),
    .timeout   (wd_timeout),
    .clear     (fault_ack),
    .expired_r (wd_expired)
  );

  dsw_dc_cmp u_dc (
    .mclk      (mclk),
    .rstn      (rstn),
    .dc        (dc),
    .interlock (drive.interlock),
    .in_tol_r  (dc_in_tol),
    .above_r   (dc_above),
    .dc_low_r  (dc_low),
    .chg_sw_r  (chg_sw)
  );

  // watchdog expiry puts the drive into its fault state
  assign fault_any = drive.fault || wd_expired;

  // fieldbus status terms
  assign ready_on = !fault_any && drive.run_enable_in &&
                    !drive.forced_open && !drive.quick_stop;

  assign ready_run = cw_r[CW_BIT_ON] && drive.dc_ready &&
                     drive.brk_close_cmd && drive.brk_feedback;

  assign running = drive.run_state && drive.modulating;

  // any one of these forces a coasting stop
  assign coast_stop = !drive.run_enable_in || drive.quick_stop ||
                      !drive.brk_feedback || !drive.brk_close_cmd ||
                      drive.forced_open;

  assign run_enabled = !coast_stop;

  assign no_qstop = !drive.quick_stop;

  // polarity taken from the bit table: one means agreement
  assign brk_agree = (drive.brk_request == drive.brk_internal);

  // application ready blocks start on low dc and on faults
  assign app_ready = drive.start_ready && !dc_low && !fault_any;

  // fieldbus status word assembly
  always_comb begin
    fs_nxt               = 16'h0000;
    fs_nxt[FS_READY_ON]  = ready_on;
    fs_nxt[FS_READY_RUN] = ready_run;
    fs_nxt[FS_RUNNING]   = running;
    fs_nxt[FS_FAULT]     = fault_any;
    fs_nxt[FS_RUN_EN]    = run_enabled;
    fs_nxt[FS_NO_QSTOP]  = no_qstop;
    fs_nxt[FS_BRK_AGREE] = brk_agree;
    fs_nxt[FS_WARNING]   = drive.warning;
    fs_nxt[FS_IN_TOL]    = dc_in_tol;
    fs_nxt[FS_FB_CTRL]   = drive.fb_ctrl_active;
    fs_nxt[FS_ABOVE]     = dc_above;
    fs_nxt[FS_CHARGE]    = drive.charge_out;
    fs_nxt[FS_WD_ECHO]   = cw_r[CW_BIT_WDOG];
  end

  // application status word assembly
  always_comb begin
    as_nxt              = 16'h0000;
    as_nxt[AS_READY]    = app_ready;
    as_nxt[AS_RUNNING]  = drive.modulating;
    as_nxt[AS_FAULT]    = fault_any;
    as_nxt[AS_RUN_EN]   = drive.mc_run_enable;
    as_nxt[AS_WARNING]  = drive.warning;
    as_nxt[AS_CHG_SW]   = chg_sw;
    as_nxt[AS_BRK_CMD]  = drive.brk_close_cmd;
    as_nxt[AS_BRK_FB]   = drive.brk_feedback;
    as_nxt[AS_CHG_CTRL] = drive.charge_cont;
    as_nxt[AS_RUN_REQ]  = drive.mc_run_request;
  end

  // registered words: warning is a plain level, no latch, no ack
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fs_r <= FS_RST;
    end else begin
      fs_r <= fs_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      as_r <= AS_RST;
    end else begin
      as_r <= as_nxt;
    end
  end

  // change pulses let a fieldbus driver send only fresh words
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fb_chg_r <= 1'b0;
    end else begin
      fb_chg_r <= (fs_nxt != fs_r);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      app_chg_r <= 1'b0;
    end else begin
      app_chg_r <= (as_nxt != as_r);
    end
  end

  assign fb_status   = fs_r;
  assign app_status  = as_r;
  assign fault_state = fs_r[FS_FAULT];
  assign wd_fault    = wd_expired;
  assign fb_changed  = fb_chg_r;
  assign app_changed = app_chg_r;

endmodule // dsw_status

// ### dsw_status_properties.sv
// concurrent checks on the status word builder ports
module dsw_status_properties #(
  parameter int TICK_CYC = dsw_pkg::WD_TICK_CYC  // cycles per millisecond
)(
  input wire logic                         mclk,        // system clock
  input wire logic                         rstn,        // async reset
  input wire logic [dsw_pkg::CW_W-1:0]     cw,          // control word
  input wire logic                         cw_stb,      // word strobe
  input wire logic [dsw_pkg::WD_SET_W-1:0] wd_timeout,  // ms, 0 = off
  input wire dsw_pkg::dsw_drive_t          drive,       // drive state
  input wire logic [15:0]                  fb_status,   // fieldbus word
  input wire logic [15:0]                  app_status,  // application word
  input wire logic                         fault_state, // drive faulted
  input wire logic                         wd_fault,    // watchdog trip
  input wire logic                         fb_changed,  // fb word moved
  input wire logic                         app_changed  // app word moved
);
  timeunit 1ns;
  timeprecision 100ps;
  import dsw_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // a second word right behind moves the echo on again
  sequence s_taken;
    cw_stb ##1 !cw_stb;
  endsequence

  sequence s_trip;
    $rose(wd_fault) ##0 (wd_timeout != 16'h0000);
  endsequence

  property p_ready_on;
    (drive.fault || !drive.run_enable_in || drive.forced_open ||
     drive.quick_stop) |=> !fb_status[FS_READY_ON];
  endproperty
  a_ready_on: assert property (p_ready_on)
    else $error("ready-on set while a blocking cause holds");

  property p_coast;
    (!drive.run_enable_in || drive.quick_stop || drive.forced_open ||
     !drive.brk_feedback) |=> !fb_status[FS_RUN_EN];
  endproperty
  a_coast: assert property (p_coast)
    else $error("run-enabled bit set during a coast stop cause");

  property p_fault;
    drive.fault |=> fault_state && fb_status[FS_FAULT]
      && app_status[AS_FAULT];
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault not reported one cycle after it arose");

  property p_qstop;
    1'b1 |=> fb_status[FS_NO_QSTOP] != $past(drive.quick_stop);
  endproperty
  a_qstop: assert property (p_qstop)
    else $error("quick stop bit not inverted");

  property p_warn;
    1'b1 |=> fb_status[FS_WARNING] == $past(drive.warning)
      && app_status[AS_WARNING] == $past(drive.warning);
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning bits do not follow the warning input");

  property p_rsvd;
    fb_status[13:11] == 3'h0 && app_status[0] == 1'b0
      && app_status[5:4] == 2'h0 && app_status[15:13] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved status bit is set");

  property p_echo;
    s_taken |=> fb_status[FS_WD_ECHO] == $past(cw[CW_BIT_WDOG], 2);
  endproperty
  a_echo: assert property (p_echo)
    else $error("watchdog echo differs from received bit");

  property p_wd_off;
    wd_timeout == 16'h0000 |=> !wd_fault;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog trip with supervision off");

  property p_trip;
    s_trip |=> fault_state && fb_status[FS_FAULT];
  endproperty
  a_trip: assert property (p_trip)
    else $error("watchdog trip did not enter fault state");

  property p_fb_chg;
    fb_changed == $changed(fb_status);
  endproperty
  a_fb_chg: assert property (p_fb_chg)
    else $error("fieldbus change pulse does not match the word");

  property p_app_chg;
    app_changed == $changed(app_status);
  endproperty
  a_app_chg: assert property (p_app_chg)
    else $error("application change pulse does not match the word");
endmodule // dsw_status_properties

// ### dsw_status_tb.sv
// self-checking bench for the status word builder
module dsw_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dsw_pkg::*;
  localparam int TICK  = 4;
  localparam int LIMIT = 2000;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] wd_timeout = 16'h0000;
  dsw_drive_t  drv = '0;
  dsw_dc_t     dcv = '0;
  logic [15:0] base = 16'h0000;
  logic        tog_en = 1'b0;
  logic [15:0] cw;
  logic [15:0] fb_status;
  logic [15:0] app_status;
  logic        cw_stb;
  logic        fault_state;
  logic        wd_fault;
  logic        chg = 1'b0;  // expected charging switch state
  logic        wdx = 1'b0;  // expected watchdog trip
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [15:0] acts [8] = '{16'h0064, 16'h0069, 16'h006A, 16'h0079,
                            16'h005F, 16'h0059, 16'h0064, 16'h0079};

  always #2.5 mclk = ~mclk;

  dsw_master u_master (.mclk(mclk), .rstn(rstn), .toggle_en(tog_en),
    .base(base), .cw(cw), .cw_stb(cw_stb));
  dsw_status #(.TICK_CYC(TICK)) dut (.mclk(mclk), .rstn(rstn), .cw(cw),
    .cw_stb(cw_stb), .wd_timeout(wd_timeout), .drive(drv), .dc(dcv),
    .fb_status(fb_status), .app_status(app_status),
    .fault_state(fault_state), .wd_fault(wd_fault), .fb_changed(),
    .app_changed());

  task automatic chk(input string what, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [15:0] exp_fb();
    logic       f;
    logic [15:0] w;
    logic [15:0] a;
    f = drv.fault | wdx;
    a = dcv.actual;
    w = 16'h0000;
    w[FS_READY_ON] = !f & drv.run_enable_in & !drv.forced_open
                     & !drv.quick_stop;
    w[FS_READY_RUN] = base[CW_BIT_ON] & drv.dc_ready & drv.brk_close_cmd
                      & drv.brk_feedback;
    w[FS_RUNNING] = drv.run_state & drv.modulating;
    w[FS_FAULT] = f;
    w[FS_RUN_EN] = drv.run_enable_in & !drv.quick_stop & drv.brk_feedback
                   & drv.brk_close_cmd & !drv.forced_open;
    w[FS_NO_QSTOP] = !drv.quick_stop;
    w[FS_BRK_AGREE] = drv.brk_request == drv.brk_internal;
    w[FS_WARNING] = drv.warning;
    w[FS_IN_TOL] = ((a >= dcv.reference) ? a - dcv.reference
                    : dcv.reference - a) <= dcv.tolerance;
    w[FS_FB_CTRL] = drv.fb_ctrl_active;
    w[FS_ABOVE] = a > dcv.threshold;
    w[FS_CHARGE] = drv.charge_out;
    w[FS_WD_ECHO] = u_master.wd_r;
    return w;
  endfunction

  function automatic logic [15:0] exp_app();
    logic [15:0] w;
    w = 16'h0000;
    w[AS_READY] = drv.start_ready & !(dcv.actual < dcv.open_level)
                  & !(drv.fault | wdx);
    w[AS_RUNNING] = drv.modulating;
    w[AS_FAULT] = drv.fault | wdx;
    w[AS_RUN_EN] = drv.mc_run_enable;
    w[AS_WARNING] = drv.warning;
    w[AS_CHG_SW] = chg;
    w[AS_BRK_CMD] = drv.brk_close_cmd;
    w[AS_BRK_FB] = drv.brk_feedback;
    w[AS_CHG_CTRL] = drv.charge_cont;
    w[AS_RUN_REQ] = drv.mc_run_request;
    return w;
  endfunction

  // one watchdog toggle per vector, so the echo takes both values
  task automatic apply(input dsw_drive_t d, input logic [15:0] act,
                       input logic b0);
    drv = d;
    dcv.actual = act;
    base[CW_BIT_ON] = b0;
    if (act > dcv.close_limit && !d.interlock) chg = 1'b1;
    else if (act < dcv.open_level || d.interlock) chg = 1'b0;
    tog_en = 1'b1;
    step(2);
    tog_en = 1'b0;
    step(5);
    chk("fb_status", fb_status, exp_fb());
    chk("app_status", app_status, exp_app());
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    dsw_drive_t d;
    dcv = '{16'h0000, 16'h0064, 16'h0005, 16'h0064, 16'h0078, 16'h005A};
    repeat (8) @(posedge mclk);
    #1;
    chk("fb_rst", fb_status, FS_RST);
    chk("app_rst", app_status, AS_RST);
    rstn = 1'b1;
    d = '0;
    d.start_ready = 1'b1;
    foreach (acts[k]) apply(d, acts[k], 1'b1);
    for (int i = 0; i < 19; i++) begin
      d = dsw_drive_t'(19'h00001 << i);
      apply(d, 16'h0064, i[0]);
      apply(~d, 16'h0079, i[0] | i[1]);
    end
    apply('0, 16'h0064, 1'b0);
    tog_en = 1'b1;
    step(4);
    // arm only once toggling runs, else a stray tick trips at once
    wd_timeout = 16'h0001;
    step(36);
    chk("wd_alive", {15'h0000, wd_fault}, 16'h0000);
    tog_en = 1'b0;
    step(12);
    wdx = 1'b1;
    chk("wd_trip", {15'h0000, wd_fault}, 16'h0001);
    chk("fb_trip", fb_status, exp_fb());
    tog_en = 1'b1;
    step(4);
    // an ack while the count still reads expired loses to the trip
    base[CW_BIT_RESET] = 1'b1;
    step(6);
    wdx = 1'b0;
    chk("wd_ack", {15'h0000, wd_fault}, 16'h0000);
    tog_en = 1'b0;
    base[CW_BIT_RESET] = 1'b0;
    step(12);
    chk("wd_again", {15'h0000, wd_fault}, 16'h0001);
    wd_timeout = 16'h0000;
    step(3);
    chk("wd_off", {15'h0000, wd_fault}, 16'h0000);
    chk("app_off", app_status, exp_app());
    give_verdict();
  end
endmodule // dsw_status_tb

bind dsw_status dsw_status_properties #(.TICK_CYC(TICK_CYC)) u_props (
  .mclk(mclk), .rstn(rstn), .cw(cw), .cw_stb(cw_stb),
  .wd_timeout(wd_timeout), .drive(drive), .fb_status(fb_status),
  .app_status(app_status), .fault_state(fault_state),
  .wd_fault(wd_fault), .fb_changed(fb_changed),
  .app_changed(app_changed));

// ### dsw_wdog.sv
// supervision of the master's toggling watchdog bit
module dsw_wdog
  import dsw_pkg::*;
#(
  parameter int TICK_CYC = WD_TICK_CYC  // cycles per millisecond
)(
  input  wire logic                mclk,      // system clock
  input  wire logic                rstn,      // async reset, active low
  input  wire logic                cw_stb,    // new control word taken
  input  wire logic                toggled,   // bit 11 changed
  input  wire logic [WD_SET_W-1:0] timeout,   // ms, zero disables
  input  wire logic                clear,     // fault acknowledge
  output logic                     expired_r  // watchdog fault
);
  localparam int TW = $clog2(TICK_CYC + 1);
  logic [TW-1:0]       tick_cnt_r;
  logic                tick;
  logic [WD_SET_W-1:0] ms_cnt_r;
  logic                armed_r;
  logic                enabled;

  assign enabled = (timeout != '0);
  assign tick    = (tick_cnt_r == TW'(TICK_CYC - 1));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
    end else if (tick || toggled) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // armed by the first word so power-up silence is not a fault
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      armed_r <= 1'b0;
    end else if (cw_stb) begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt_r <= '0;
    end else if (!enabled || toggled) begin
      ms_cnt_r <= '0;
    end else if (tick && ms_cnt_r != timeout) begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  // expiry wins over a same-cycle acknowledge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      expired_r <= 1'b0;
    end else if (enabled && armed_r && ms_cnt_r == timeout) begin
      expired_r <= 1'b1;
    end else if (clear || !enabled) begin
      expired_r <= 1'b0;
    end
  end
endmodule // dsw_wdog
